// ==== core/mixer_defs.svh ====
// Register offsets, field positions, reset values and timing counts of the conference mixer
`ifndef MIXER_DEFS_SVH
`define MIXER_DEFS_SVH

`define OFF_MIX_CONTROL 12'h018
`define OFF_SLOT_SELECT 12'h01c
`define OFF_SLOT_PARAMS 12'h0d0
`define OFF_OVERFLOW 12'h014
`define OFF_SLOT_READBACK 12'h0d4
`define CTRL_ENABLE_BIT 0
`define CTRL_ULAW_BIT 7
`define PAR_GROUP_LSB 0
`define PAR_NOISE_LSB 3
`define PAR_ATT_LSB 5
`define PAR_MEMBER_BIT 7
`define CTRL_RESET 8'h00
`define PARAM_RESET 8'h00
`define FRAME_NS 125000
`define CLK_NS 40
`define FRAME_CYCLES (`FRAME_NS / `CLK_NS)
`define NOISE_LVL1 16'sd5
`define NOISE_LVL2 16'sd9
`define NOISE_LVL3 16'sd16
`define MAX_AMPL 16'sh7fff
`define MIN_AMPL 16'sh8000

`endif

// ==== core/mixer_pkg.sv ====
// Types shared by the conference mixer
package mixer_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_ACCUM, ST_OUTPUT} phase_t;

    typedef struct packed {
        logic member;
        logic [1:0] attenuation;
        logic [1:0] noise;
        logic [2:0] group;
    } slot_param_t;

    typedef struct packed {
        logic valid;
        logic [6:0] slot;
        logic [7:0] sample;
    } pcm_beat_t;
endpackage

// ==== core/conference_mixer.sv ====
// Multiparty conference mixer on the outgoing PCM path with an APB register slave
//
// Summary of operation
// (RQ1) Eight independent conferences, any number of member slots each.
// (RQ2) Member slot transmit sample is replaced by the mixed conference sample.
// (RQ3) Membership limited only by slots; up to 128 slots stored.
// (RQ4) A slot holds one conference number; software never assigns two.
// (RQ5) Per frame sum all members; each member gets sum minus own sample. A member beat in the swap cycle is left out of the new sum.
// (RQ6) Two alternating sum buffers swap every frame interval.
// (RQ7) Mixing happens only while the global enable bit is set.
// (RQ8) Software avoids 8 Mbit/s with 128 slots unless clock doubled.
// (RQ9) Software selects slot, links channel, then writes conference number.
// (RQ10) Noise threshold and attenuation stored and applied per slot.
// (RQ11) Software removes a slot by selecting it and writing zero.
// (RQ12) All sums and differences are signed 16-bit words.
// (RQ13) Out-of-range sums saturate to the maximum amplitude.
// (RQ14) Overflow register has one flag per conference, set on saturation.
// (RQ15) Attenuation writes accepted on the fly while running.
// (RQ16) Line members use a looped transmit/receive slot pair set by software.
// (RQ17) Line members need one transmit and one receive FIFO enabled.
// (RQ18) PCM members enable membership on transmit slot only.
// (RQ19) Reading the overflow register returns flags then clears them.
// (RQ20) Attenuation codes 0..3 give 0, -3, -6, -9 dB.
// (RQ21) Noise codes 1..3 zero magnitudes at or below 5, 9, 16.
// (RQ22) Companding is A-law when select is 0, mu-law when 1.
// (RQ23) After reset flags are clear and no slot is a member.
`timescale 1ns/1ps
`include "mixer_defs.svh"

module conference_mixer
    import mixer_pkg::*;
#(
    parameter int SLOTS = 128,
    parameter int GROUPS = 8,
    parameter int FRAME_CYCLES = `FRAME_CYCLES
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Outgoing PCM stream, before and after mixing
    input pcm_beat_t tx_in,
    output pcm_beat_t tx_out,
    // Frame boundary seen by the mixer
    output logic frame_tick
);
    // Slot and group fields are fixed at 7 and 3 bits; frame counter is 17 bits
    if (SLOTS != 128 || GROUPS != 8 || FRAME_CYCLES < 2 || FRAME_CYCLES > 131072)
    begin
        $error("conference_mixer: unsupported parameters");
    end

    // Module state except the slot parameters and the sum banks
    typedef struct packed {
        logic [7:0] ctrl;
        logic [6:0] sel;
        logic [7:0] flags;
        logic bank;
        logic [16:0] frame_cnt;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        pcm_beat_t out;
        logic tick;
    } state_t;

    state_t q, d;
    slot_param_t params [SLOTS];
    logic signed [15:0] acc [2][GROUPS];

    // Decode an 8-bit companded code to linear, A-law or mu-law
    function automatic logic signed [15:0] expand(input logic [7:0] c, input logic ulaw);
        logic [7:0] v;
        logic [2:0] e;
        logic [14:0] m;
        v = 8'h00;
        e = 3'd0;
        m = 15'd0;
        if (ulaw)
        begin
            v = ~c;
            e = v[6:4];
            m = 15'((({11'd0, v[3:0]} << 3) + 15'd132) << e) - 15'd132;
        end
        else
        begin
            v = c ^ 8'h55;
            e = v[6:4];
            m = {7'd0, v[3:0], 4'h8};
            if (e != 3'd0)
                m = 15'((m + 15'h100) << (e - 3'd1));
        end
        expand = (v[7] ^ ulaw) ? $signed({1'b0, m}) : -$signed({1'b0, m});
    endfunction

    // Encode linear to companded code
    function automatic logic [7:0] compress(input logic signed [15:0] s, input logic ulaw);
        logic [15:0] mag;
        logic [2:0] e;
        logic [3:0] mm;
        logic neg;
        neg = s[15];
        mag = neg ? 16'(-s) : 16'(s);
        e = 3'd0;
        mm = 4'h0;
        if (ulaw)
        begin
            if (mag > 16'd32635)
                mag = 16'd32635;
            mag = mag + 16'd132;
            for (int i = 7; i >= 0; i--)
                if (e == 3'd0 && mag[i + 7])
                    e = 3'(i);
            // Widened sum, so exponents 5..7 do not wrap the shift amount
            mm = 4'(mag >> (4'(e) + 4'd3));
            compress = ~{neg, e, mm};
        end
        else
        begin
            for (int i = 7; i >= 1; i--)
                if (e == 3'd0 && mag[i + 7])
                    e = 3'(i);
            mm = (e == 3'd0) ? 4'(mag >> 4) : 4'(mag >> (4'(e) + 4'd3));
            compress = {~neg, e, mm} ^ 8'h55;
        end
    endfunction

    // Attenuation and noise gate of one slot input
    function automatic logic signed [15:0] condition(input logic signed [15:0] s,
                                                     input slot_param_t p);
        logic signed [15:0] a;
        logic signed [15:0] mag;
        logic signed [15:0] lvl;
        // Close binary approximations of 0.708, 0.5, 0.354 gain
        case (p.attenuation) // RQ20
            2'd0: a = s;
            2'd1: a = (s >>> 1) + (s >>> 3) + (s >>> 4) + (s >>> 6);
            2'd2: a = s >>> 1;
            default: a = (s >>> 2) + (s >>> 4) + (s >>> 5) + (s >>> 7);
        endcase
        case (p.noise) // RQ21
            2'd1: lvl = `NOISE_LVL1;
            2'd2: lvl = `NOISE_LVL2;
            2'd3: lvl = `NOISE_LVL3;
            default: lvl = -16'sd1;
        endcase
        mag = a[15] ? -a : a;
        condition = (mag <= lvl) ? 16'sd0 : a;
    endfunction

    // Saturating signed 16-bit add
    function automatic logic [16:0] sat_add(input logic signed [15:0] x,
                                            input logic signed [15:0] y);
        logic signed [16:0] w;
        w = 17'(x) + 17'(y); // RQ12
        if (w > 17'sd32767)
            sat_add = {1'b1, `MAX_AMPL}; // RQ13
        else if (w < -17'sd32768)
            sat_add = {1'b1, `MIN_AMPL};
        else
            sat_add = {1'b0, w[15:0]};
    endfunction

    // Combinational view of the current beat
    logic bus_setup;
    logic bus_write;
    logic bus_read;
    logic enabled;
    logic ulaw;
    slot_param_t cur;
    logic signed [15:0] own;
    logic [16:0] acc_sum;
    logic [16:0] mix_out;
    logic [2:0] grp;

    always_comb
    begin
        bus_setup = psel && !penable;
        bus_write = psel && penable && pwrite && q.pready;
        bus_read = psel && penable && !pwrite && q.pready;
        enabled = q.ctrl[`CTRL_ENABLE_BIT]; // RQ7
        ulaw = q.ctrl[`CTRL_ULAW_BIT]; // RQ22
        cur = params[tx_in.slot];
        grp = cur.group;
        own = condition(expand(tx_in.sample, ulaw), cur); // RQ10
        acc_sum = sat_add(acc[q.bank][grp], own);
        // Last frame's total less this member's own share
        mix_out = sat_add(acc[~q.bank][grp], -own); // RQ5
    end

    // Next state
    always_comb
    begin
        d = q;
        d.tick = 1'b0;
        d.pready = 1'b0;
        d.pslverr = 1'b0;
        d.out = tx_in;
        // Frame interval divider
        if (q.frame_cnt == 17'(FRAME_CYCLES - 1))
        begin
            d.frame_cnt = 17'd0;
            d.tick = 1'b1;
            d.bank = ~q.bank; // RQ6
        end
        else
            d.frame_cnt = q.frame_cnt + 17'd1;
        // Replace transmit sample of members with the mix
        if (tx_in.valid && enabled && cur.member) // RQ2
        begin
            d.out.sample = compress(mix_out[15:0], ulaw);
            if (acc_sum[16] || mix_out[16])
                d.flags[grp] = 1'b1; // RQ14
        end
        // APB: one wait state, answer at second access cycle
        if (psel && penable && !q.pready)
        begin
            d.pready = 1'b1;
            d.prdata = 32'h0000_0000;
            case (paddr)
                `OFF_MIX_CONTROL: d.prdata = {24'h000000, q.ctrl};
                `OFF_SLOT_SELECT: d.prdata = {25'h0000000, q.sel};
                `OFF_SLOT_PARAMS: d.prdata = {24'h000000, params[q.sel]};
                `OFF_OVERFLOW: d.prdata = {24'h000000, q.flags};
                default: d.pslverr = 1'b1;
            endcase
        end
        if (bus_write && paddr == `OFF_MIX_CONTROL)
            d.ctrl = pwdata[7:0] & 8'h81;
        if (bus_write && paddr == `OFF_SLOT_SELECT)
            d.sel = pwdata[6:0];
        // Read clears only flags already reported; later saturations wait for next read
        if (bus_read && paddr == `OFF_OVERFLOW) // RQ19
        begin
            d.flags = q.flags & ~q.prdata[7:0];
            if (tx_in.valid && enabled && cur.member && (acc_sum[16] || mix_out[16]))
                d.flags[grp] = 1'b1;
        end
        if (bus_setup)
            d.pready = 1'b0;
    end

    // Register the state
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            q <= '0;
            q.ctrl <= `CTRL_RESET;
            q.flags <= 8'h00; // RQ23
        end
        else
            q <= d;
    end

    // Slot parameter store; attenuation writes take effect at once
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < SLOTS; i++)
                params[i] <= `PARAM_RESET; // RQ23
        end
        else if (bus_write && paddr == `OFF_SLOT_PARAMS)
            params[q.sel] <= pwdata[7:0]; // RQ15
    end

    // Two sum banks: build one, read the other; clear on swap
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            for (int b = 0; b < 2; b++)
                for (int g = 0; g < GROUPS; g++)
                    acc[b][g] <= 16'sd0;
        end
        else
        begin
            if (q.tick)
            begin
                for (int g = 0; g < GROUPS; g++)
                    acc[q.bank][g] <= 16'sd0;
            end
            if (tx_in.valid && enabled && cur.member && !q.tick) // RQ1 RQ3 RQ4
                acc[q.bank][grp] <= acc_sum[15:0]; // RQ5
        end
    end

    // Outputs straight from the state register
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign tx_out = q.out;
    assign frame_tick = q.tick;
endmodule

// ==== sim/mixer_properties.sv ====
// Port protocol checker for the conference mixer
`timescale 1ns/1ps
`include "mixer_defs.svh"
module mixer_properties
    import mixer_pkg::*;
#(
    parameter int FRAME_CYCLES = 16
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Sample stream
    input pcm_beat_t tx_in,
    input pcm_beat_t tx_out,
    input wire logic frame_tick
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    int cnt_q;
    logic seen_q;
    // Frame age; first tick after reset has no reference
    always_ff @(posedge core_clk)
    begin
        cnt_q <= (rst || frame_tick) ? 0 : cnt_q + 1;
        seen_q <= rst ? 1'b0 : (seen_q || frame_tick);
    end
    // Access phase opens
    sequence access_start;
        psel && penable && !$past(penable);
    endsequence
    sequence late_ready;
        !pready ##1 pready;
    endsequence
    ready_timing_a: assert property (access_start |-> late_ready)
        else $error("answer not on second access cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    flags_mapped_a: assert property (pready && paddr == `OFF_OVERFLOW |-> !pslverr)
        else $error("flag register refused");
    upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    beat_follow_a: assert property (tx_in.valid |=> tx_out.valid && tx_out.slot == $past(tx_in.slot))
        else $error("beat lost or moved");
    no_stray_a: assert property (!tx_in.valid |=> !tx_out.valid)
        else $error("beat from nowhere");
    frame_period_a: assert property (frame_tick && seen_q |-> cnt_q == FRAME_CYCLES - 1)
        else $error("bank swap period wrong");
    reset_quiet_a: assert property ($past(rst) |-> !pready && !frame_tick && !tx_out.valid)
        else $error("outputs busy after reset");
endmodule

bind conference_mixer mixer_properties #(.FRAME_CYCLES(FRAME_CYCLES)) mixer_properties_inst (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_in(tx_in), .tx_out(tx_out), .frame_tick(frame_tick));

// ==== sim/pcm_source.sv ====
// Model of the switch side feeding outgoing beats
`timescale 1ns/1ps
module pcm_source
    import mixer_pkg::*;
(
    // Clock and bench request
    input wire logic core_clk,
    input wire logic send,
    input wire logic [6:0] slot,
    input wire logic [7:0] sample,
    // Beats into the mixer
    output pcm_beat_t beat
);
    initial beat = '0;
    // One valid cycle per request; idle fields toggle so stale data is never reused
    always @(posedge core_clk)
    begin
        // Looped line members arrive as plain transmit beats, never receive slots
        beat.valid <= send;
        beat.slot <= send ? slot : ~beat.slot;
        beat.sample <= send ? sample : ~beat.sample;
    end
endmodule

// ==== sim/test_pcm_audio_conference_mixer.sv ====
// Self-checking bench for the conference mixer
`timescale 1ns/1ps
`include "mixer_defs.svh"
module test_pcm_audio_conference_mixer
    import mixer_pkg::*;
;
    typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e; logic x;} row_t;
    logic core_clk = 0;
    logic rst = 1;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready;
    logic pslverr;
    logic er;
    logic send = 0;
    logic [6:0] slot = 7'h00;
    logic [7:0] sample = 8'h00;
    logic [7:0] got;
    pcm_beat_t tx_in;
    pcm_beat_t tx_out;
    logic frame_tick;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    // Register rows: write, address, write data, expected read, expected slave error
    row_t rows[8] = '{'{0, 12'h014, 0, 0, 0}, '{0, 12'h018, 0, 0, 0},
        '{1, 12'h018, 32'h81, 0, 0}, '{0, 12'h018, 0, 32'h81, 0}, '{1, 12'h014, 32'hff, 0, 0},
        '{0, 12'h014, 0, 0, 0}, '{0, 12'h040, 0, 0, 1}, '{1, 12'h018, 0, 0, 0}};

    conference_mixer #(.FRAME_CYCLES(16)) conference_mixer_inst (.core_clk(core_clk),
        .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_in(tx_in), .tx_out(tx_out), .frame_tick(frame_tick));
    pcm_source pcm_source_inst (.core_clk(core_clk), .send(send), .slot(slot),
        .sample(sample), .beat(tx_in));

    initial
    begin
        forever #20 core_clk = ~core_clk;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        cmp_count++;
        if (g !== e)
        begin
            errors++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask

    // Bus cycle; request held until ready is seen
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            errors++;
            $display("mismatch at %0t: bus answer missing", $time);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic beat(input logic [6:0] s, input logic [7:0] v);
        int n;
        n = 0;
        @(posedge core_clk);
        send <= 1'b1;
        slot <= s;
        sample <= v;
        @(posedge core_clk);
        send <= 1'b0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (tx_out.valid !== 1'b1 && n < 8);
        if (tx_out.valid !== 1'b1)
        begin
            errors++;
            $display("mismatch at %0t: beat missing", $time);
        end
        got = tx_out.sample;
    endtask

    // Beats kept clear of the swap cycle
    task automatic wait_tick();
        int n;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (frame_tick !== 1'b1 && n < 40);
        if (frame_tick !== 1'b1)
        begin
            errors++;
            $display("mismatch at %0t: frame tick missing", $time);
        end
        @(posedge core_clk);
    endtask

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Hang guard
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            errors++;
            wrap_up();
        end
    end

    initial
    begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        foreach (rows[i])
        begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            chk({31'h0, er}, {31'h0, rows[i].x}, "slave error");
            if (!rows[i].w && !rows[i].x)
                chk(rd, rows[i].e, "read data");
        end
        $display("test registers done");
        beat(7'd3, 8'h5a);
        chk({24'h0, got}, 32'h5a, "idle mixer altered beat");
        for (int m = 0; m < 8; m++)
        begin
            apb(1, `OFF_MIX_CONTROL, {24'h0, m[0], 7'h01});
            apb(1, `OFF_SLOT_SELECT, 32'h9);
            apb(1, `OFF_SLOT_PARAMS, {24'h0, 1'b1, m[1:0], m[2:1], m[2:0]});
            repeat (3)
            begin
                wait_tick();
                beat(7'd9, 8'h10);
            end
            chk({24'h0, got}, m[0] ? 32'hff : 32'hd5, "lone member hears itself");
        end
        $display("test mixing done");
        apb(1, `OFF_SLOT_PARAMS, 32'h0);
        beat(7'd9, 8'h10);
        chk({24'h0, got}, 32'h10, "removed slot still mixed");
        apb(1, `OFF_SLOT_SELECT, 32'ha);
        apb(1, `OFF_SLOT_PARAMS, 32'h85);
        apb(1, `OFF_SLOT_SELECT, 32'hb);
        apb(1, `OFF_SLOT_PARAMS, 32'h85);
        wait_tick();
        beat(7'd10, 8'h80);
        beat(7'd11, 8'h80);
        apb(0, `OFF_OVERFLOW, 0);
        chk(rd, 32'h20, "overflow flag");
        apb(0, `OFF_OVERFLOW, 0);
        chk(rd, 32'h0, "flags not cleared");
        $display("test overflow done");
        apb(1, `OFF_SLOT_PARAMS, 32'h80);
        rst <= 1'b1;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        apb(0, `OFF_MIX_CONTROL, 0);
        chk(rd, 32'h0, "control after reset");
        apb(1, `OFF_MIX_CONTROL, 32'h1);
        beat(7'd11, 8'h33);
        chk({24'h0, got}, 32'h33, "member survived reset");
        $display("test reset done");
        // Group 1 in mu-law: slot 12 at -6 dB, slot 13 gated at 16 or below
        apb(1, `OFF_MIX_CONTROL, 32'h81);
        apb(1, `OFF_SLOT_SELECT, 32'hc);
        apb(1, `OFF_SLOT_PARAMS, 32'hc1);
        apb(1, `OFF_SLOT_SELECT, 32'hd);
        apb(1, `OFF_SLOT_PARAMS, 32'h99);
        wait_tick();
        beat(7'd12, 8'hcf);
        beat(7'd13, 8'hfd);
        wait_tick();
        // Slot 12 carries 924, halved to 462
        beat(7'd13, 8'hfd);
        chk({24'h0, got}, 32'hdd, "attenuated member not halved");
        // Slot 13 carries 16, forced to zero
        beat(7'd12, 8'hcf);
        chk({24'h0, got}, 32'hff, "gated member still heard");
        $display("test attenuation done");
        wrap_up();
    end
endmodule
